// ### rtl/mic_pkg.sv
// Function
// [RQ1] Accept five request pins, eight wake-up pins and 23 internal causes; the code takes 24 internal cause inputs.
// [RQ2] Among pending requests only the lowest vector number is serviced.
// [RQ3] Global mask set: flags still set, no interrupt accepted.
// [RQ4] Every request pin and wake-up pin picks rising or falling edge.
// [RQ5] Request pins 0-4 use vectors 4-8; wake-up group uses vector 9.
// [RQ6] Timer A overflow is vector 11, event counter overflow vector 12.
// [RQ7] Timer C overflow and underflow share vector 13.
// [RQ8] Timer F low half vector 14, high half vector 15.
// [RQ9] Timer G capture and overflow share vector 16.
// [RQ10] Each serial channel merges six causes: vectors 17 and 18.
// [RQ11] Conversion end vector 19; sleep direct transfer vector 20, lowest.
// [RQ12] Vectors 1-3 and 10 are reserved and never issued.
// [RQ13] Pending flags clear only on a written 0; a written 1 keeps them.
// [RQ14] Edge-select bits 7-5 read as 1 and ignore writes.
// [RQ15] Edge-select bit 4 sets edge of pin 4 and converter trigger.
// [RQ16] Edge-select bits 3-0 set pins 3-0; bit 3 timer F, bit 1 timer C pin.
// [RQ17] Enable one: timer A bit 7, wake-up group bit 5, pins bits 4-0.
// [RQ18] Request reaches core only if flag, enable set and mask clear.
package mic_pkg;
  // ----------------------------------------
  // Register word indices
  // ----------------------------------------
  localparam logic [15:0] ADDR_WAKEUP_EDGE = 16'hFF90;
  localparam logic [15:0] ADDR_REQ_EDGE = 16'hFFF2;
  localparam logic [15:0] ADDR_ENABLE_ONE = 16'hFFF3;
  localparam logic [15:0] ADDR_ENABLE_TWO = 16'hFFF4;
  localparam logic [15:0] ADDR_PEND_ONE = 16'hFFF6;
  localparam logic [15:0] ADDR_PEND_TWO = 16'hFFF7;
  localparam logic [15:0] ADDR_WAKEUP_PEND = 16'hFFF9;
  // Offsets not multiple of four: above are indices, byte address is index * 4
  localparam int ADDR_SHIFT = 2;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_WAKEUP_EDGE = 8'h00;
  localparam logic [7:0] RST_REQ_EDGE = 8'hE0;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_PEND_ONE = 8'h20;
  localparam logic [7:0] RST_PEND_TWO = 8'h00;
  localparam logic [7:0] RST_WAKEUP_PEND = 8'h00;
  localparam logic [7:0] REQ_EDGE_FIXED = 8'hE0;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_TIMER_A = 7;
  localparam int BIT_WAKEUP = 5;
  localparam int BIT_DIRECT = 7;
  localparam int BIT_CONV = 6;
  localparam int BIT_TIMER_G = 4;
  localparam int BIT_TIMER_FH = 3;
  localparam int BIT_TIMER_FL = 2;
  localparam int BIT_TIMER_C = 1;
  localparam int BIT_EVENT_CNT = 0;
  localparam int BIT_PIN4 = 4;
  localparam int BIT_PIN3 = 3;
  localparam int BIT_PIN1 = 1;
  // ----------------------------------------
  // Vector numbers
  // ----------------------------------------
  localparam logic [4:0] VEC_PIN0 = 5'h04;
  localparam logic [4:0] VEC_WAKEUP = 5'h09;
  localparam logic [4:0] VEC_TIMER_A = 5'h0B;
  localparam logic [4:0] VEC_EVENT_CNT = 5'h0C;
  localparam logic [4:0] VEC_TIMER_C = 5'h0D;
  localparam logic [4:0] VEC_TIMER_FL = 5'h0E;
  localparam logic [4:0] VEC_TIMER_FH = 5'h0F;
  localparam logic [4:0] VEC_TIMER_G = 5'h10;
  localparam logic [4:0] VEC_SERIAL1 = 5'h11;
  localparam logic [4:0] VEC_SERIAL2 = 5'h12;
  localparam logic [4:0] VEC_CONV = 5'h13;
  localparam logic [4:0] VEC_DIRECT = 5'h14;
  localparam int NUM_SLOTS = 16;
endpackage : mic_pkg

// ### rtl/mic_edge_detect.sv
`timescale 1ns/1ps
// ----------------------------------------
// Selectable edge detector, one per pin
// ----------------------------------------
module mic_edge_detect #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin,
  input wire logic [WIDTH-1:0] rising,
  output logic [WIDTH-1:0] hit
);
  logic [WIDTH-1:0] prev_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_ff <= '1;
    else
      prev_ff <= pin;
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      // Rising when select is 1, falling otherwise
      assign hit[g] = rising[g] ? (pin[g] & ~prev_ff[g]) : (~pin[g] & prev_ff[g]); // [RQ4]
    end
  endgenerate
endmodule : mic_edge_detect

// ### rtl/mic_prio_encode.sv
`timescale 1ns/1ps
// ----------------------------------------
// Fixed priority: slot 0 highest
// ----------------------------------------
module mic_prio_encode #(
  parameter int N = 16
) (
  input wire logic [N-1:0] req,
  output logic any,
  output logic [$clog2(N)-1:0] idx
);
  always_comb
  begin
    any = |req;
    idx = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
        idx = i[$clog2(N)-1:0]; // [RQ2]
    end
  end
endmodule : mic_prio_encode

// ### rtl/mic_interrupt_controller.sv
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module mic_interrupt_controller (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] request_pin,
  input wire logic [7:0] wakeup_pin,
  input wire logic timer_f_event_pin,
  input wire logic timer_c_event_pin,
  input wire logic converter_trigger_pin,
  input wire logic timer_a_ovf,
  input wire logic event_cnt_ovf,
  input wire logic [1:0] timer_c_event,
  input wire logic [1:0] timer_fl_event,
  input wire logic [1:0] timer_fh_event,
  input wire logic [1:0] timer_g_event,
  input wire logic [5:0] serial1_event,
  input wire logic [5:0] serial2_event,
  input wire logic conv_end,
  input wire logic sleep_exec,
  input wire logic global_mask,
  input wire logic irq_ack,
  output logic irq,
  output logic [4:0] irq_vector,
  output logic [15:0] irq_vector_addr,
  output logic timer_f_pin_hit,
  output logic timer_c_pin_hit,
  output logic converter_trigger_hit
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] wakeup_edge_select_ff;
  logic [4:0] request_edge_select_ff;
  logic [7:0] source_enable_one_ff;
  logic [7:0] source_enable_two_ff;
  logic [7:0] pending_flags_one_ff;
  logic [7:0] pending_flags_two_ff;
  logic [7:0] wakeup_pending_flags_ff;
  logic irq_ff;
  logic [4:0] vec_ff;
  logic [15:0] vec_addr_ff;
  logic [31:0] prdata_ff;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic wr_en;
  logic rd_en;
  logic [15:0] word_idx;
  logic [7:0] wbyte;
  assign word_idx = paddr[17:2];
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign wbyte = pwdata[7:0];
  assign pready = 1'b1;

  function automatic logic hit_reg(input logic [15:0] idx, input logic [15:0] reg_idx);
    hit_reg = (idx == reg_idx);
  endfunction : hit_reg

  logic mapped;
  assign mapped = hit_reg(word_idx, mic_pkg::ADDR_WAKEUP_EDGE)
                | hit_reg(word_idx, mic_pkg::ADDR_REQ_EDGE)
                | hit_reg(word_idx, mic_pkg::ADDR_ENABLE_ONE)
                | hit_reg(word_idx, mic_pkg::ADDR_ENABLE_TWO)
                | hit_reg(word_idx, mic_pkg::ADDR_PEND_ONE)
                | hit_reg(word_idx, mic_pkg::ADDR_PEND_TWO)
                | hit_reg(word_idx, mic_pkg::ADDR_WAKEUP_PEND);
  assign pslverr = psel & penable & ~mapped;

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  logic [4:0] req_hit;
  logic [7:0] wk_hit;
  logic [2:0] aux_hit;
  logic [2:0] aux_rise;

  mic_edge_detect #(.WIDTH(5)) u_req_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin(request_pin),
    .rising(request_edge_select_ff), // [RQ16]
    .hit(req_hit)
  );

  mic_edge_detect #(.WIDTH(8)) u_wk_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin(wakeup_pin),
    .rising(wakeup_edge_select_ff), // [RQ4]
    .hit(wk_hit)
  );

  // Shared polarity for timer F, timer C and converter trigger pins
  assign aux_rise = {request_edge_select_ff[mic_pkg::BIT_PIN4], // [RQ15]
                     request_edge_select_ff[mic_pkg::BIT_PIN1], // [RQ16]
                     request_edge_select_ff[mic_pkg::BIT_PIN3]}; // [RQ16]

  mic_edge_detect #(.WIDTH(3)) u_aux_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin({converter_trigger_pin, timer_c_event_pin, timer_f_event_pin}),
    .rising(aux_rise),
    .hit(aux_hit)
  );

  // ----------------------------------------
  // Pin edge pulses to timers and converter
  // ----------------------------------------
  logic [2:0] aux_hit_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      aux_hit_ff <= 3'h0;
    else
      aux_hit_ff <= aux_hit;
  end
  assign timer_f_pin_hit = aux_hit_ff[0];
  assign timer_c_pin_hit = aux_hit_ff[1];
  assign converter_trigger_hit = aux_hit_ff[2];

  // ----------------------------------------
  // Event sets
  // ----------------------------------------
  logic [7:0] set_one;
  logic [7:0] set_two;
  always_comb
  begin
    set_one = 8'h00;
    set_one[4:0] = req_hit; // [RQ1]
    set_one[mic_pkg::BIT_TIMER_A] = timer_a_ovf;
    set_two = 8'h00;
    set_two[mic_pkg::BIT_DIRECT] = sleep_exec; // [RQ11]
    set_two[mic_pkg::BIT_CONV] = conv_end;
    set_two[mic_pkg::BIT_TIMER_G] = |timer_g_event; // [RQ9]
    set_two[mic_pkg::BIT_TIMER_FH] = |timer_fh_event; // [RQ8]
    set_two[mic_pkg::BIT_TIMER_FL] = |timer_fl_event; // [RQ8]
    set_two[mic_pkg::BIT_TIMER_C] = |timer_c_event; // [RQ7]
    set_two[mic_pkg::BIT_EVENT_CNT] = event_cnt_ovf;
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wakeup_edge_select_ff <= mic_pkg::RST_WAKEUP_EDGE;
    else if (wr_en && hit_reg(word_idx, mic_pkg::ADDR_WAKEUP_EDGE))
      wakeup_edge_select_ff <= wbyte;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      request_edge_select_ff <= mic_pkg::RST_REQ_EDGE[4:0];
    else if (wr_en && hit_reg(word_idx, mic_pkg::ADDR_REQ_EDGE))
      request_edge_select_ff <= wbyte[4:0]; // [RQ14]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      source_enable_one_ff <= mic_pkg::RST_ENABLE;
    else if (wr_en && hit_reg(word_idx, mic_pkg::ADDR_ENABLE_ONE))
      source_enable_one_ff <= wbyte; // [RQ17]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      source_enable_two_ff <= mic_pkg::RST_ENABLE;
    else if (wr_en && hit_reg(word_idx, mic_pkg::ADDR_ENABLE_TWO))
      source_enable_two_ff <= wbyte;
  end

  // ----------------------------------------
  // Pending flags: zero write clears, set wins
  // ----------------------------------------
  function automatic logic [7:0] flag_next(input logic [7:0] cur, input logic [7:0] set,
                                           input logic clr_sel, input logic [7:0] wd);
    logic [7:0] kept;
    kept = clr_sel ? (cur & wd) : cur; // [RQ13]
    flag_next = kept | set; // [RQ3] [RQ18]
  endfunction : flag_next

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pending_flags_one_ff <= mic_pkg::RST_PEND_ONE;
    else
      pending_flags_one_ff <= flag_next(pending_flags_one_ff, set_one,
                                        wr_en && hit_reg(word_idx, mic_pkg::ADDR_PEND_ONE), wbyte);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pending_flags_two_ff <= mic_pkg::RST_PEND_TWO;
    else
      pending_flags_two_ff <= flag_next(pending_flags_two_ff, set_two,
                                        wr_en && hit_reg(word_idx, mic_pkg::ADDR_PEND_TWO), wbyte);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wakeup_pending_flags_ff <= mic_pkg::RST_WAKEUP_PEND;
    else
      wakeup_pending_flags_ff <= flag_next(wakeup_pending_flags_ff, wk_hit,
                                           wr_en && hit_reg(word_idx, mic_pkg::ADDR_WAKEUP_PEND),
                                           wbyte);
  end

  // Serial channels have their own flags in their modules; merged here
  logic serial1_req;
  logic serial2_req;
  assign serial1_req = |serial1_event; // [RQ10]
  assign serial2_req = |serial2_event; // [RQ10]

  // ----------------------------------------
  // Priority resolution
  // ----------------------------------------
  logic [mic_pkg::NUM_SLOTS-1:0] slot_req;
  logic [4:0] slot_vec [mic_pkg::NUM_SLOTS];
  logic any_req;
  logic [3:0] win_idx;

  always_comb
  begin
    // Slots ordered by vector; reserved vectors have no slot
    slot_req[4:0] = pending_flags_one_ff[4:0] & source_enable_one_ff[4:0]; // [RQ18]
    slot_req[5] = (|wakeup_pending_flags_ff) & source_enable_one_ff[mic_pkg::BIT_WAKEUP];
    slot_req[6] = pending_flags_one_ff[mic_pkg::BIT_TIMER_A]
                & source_enable_one_ff[mic_pkg::BIT_TIMER_A];
    slot_req[7] = pending_flags_two_ff[mic_pkg::BIT_EVENT_CNT]
                & source_enable_two_ff[mic_pkg::BIT_EVENT_CNT];
    slot_req[8] = pending_flags_two_ff[mic_pkg::BIT_TIMER_C]
                & source_enable_two_ff[mic_pkg::BIT_TIMER_C];
    slot_req[9] = pending_flags_two_ff[mic_pkg::BIT_TIMER_FL]
                & source_enable_two_ff[mic_pkg::BIT_TIMER_FL];
    slot_req[10] = pending_flags_two_ff[mic_pkg::BIT_TIMER_FH]
                 & source_enable_two_ff[mic_pkg::BIT_TIMER_FH];
    slot_req[11] = pending_flags_two_ff[mic_pkg::BIT_TIMER_G]
                 & source_enable_two_ff[mic_pkg::BIT_TIMER_G];
    slot_req[12] = serial1_req;
    slot_req[13] = serial2_req;
    slot_req[14] = pending_flags_two_ff[mic_pkg::BIT_CONV]
                 & source_enable_two_ff[mic_pkg::BIT_CONV];
    slot_req[15] = pending_flags_two_ff[mic_pkg::BIT_DIRECT]
                 & source_enable_two_ff[mic_pkg::BIT_DIRECT];
    for (int i = 0; i < 5; i++)
      slot_vec[i] = mic_pkg::VEC_PIN0 + 5'(i); // [RQ5]
    slot_vec[5] = mic_pkg::VEC_WAKEUP; // [RQ5]
    slot_vec[6] = mic_pkg::VEC_TIMER_A; // [RQ6] [RQ12]
    slot_vec[7] = mic_pkg::VEC_EVENT_CNT; // [RQ6]
    slot_vec[8] = mic_pkg::VEC_TIMER_C; // [RQ7]
    slot_vec[9] = mic_pkg::VEC_TIMER_FL; // [RQ8]
    slot_vec[10] = mic_pkg::VEC_TIMER_FH; // [RQ8]
    slot_vec[11] = mic_pkg::VEC_TIMER_G; // [RQ9]
    slot_vec[12] = mic_pkg::VEC_SERIAL1; // [RQ10]
    slot_vec[13] = mic_pkg::VEC_SERIAL2; // [RQ10]
    slot_vec[14] = mic_pkg::VEC_CONV; // [RQ11]
    slot_vec[15] = mic_pkg::VEC_DIRECT; // [RQ11]
  end

  mic_prio_encode #(.N(mic_pkg::NUM_SLOTS)) u_prio (
    .req(slot_req),
    .any(any_req),
    .idx(win_idx)
  );

  // ----------------------------------------
  // Core request outputs
  // ----------------------------------------
  // Ack drops the request for one cycle so the core never takes it twice
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_ff <= 1'b0;
    else
      irq_ff <= any_req & ~global_mask & ~irq_ack; // [RQ3] [RQ18]
  end

  // ----------------------------------------
  // Vector outputs
  // ----------------------------------------
  // Table entry is a word, so its byte address is twice the vector
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vec_ff <= 5'h00;
      vec_addr_ff <= 16'h0000;
    end
    else
    begin
      vec_ff <= slot_vec[win_idx]; // [RQ2]
      vec_addr_ff <= {10'h000, slot_vec[win_idx], 1'b0}; // [RQ5]
    end
  end
  assign irq = irq_ff;
  assign irq_vector = vec_ff;
  assign irq_vector_addr = vec_addr_ff;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      prdata_ff <= 32'h0000_0000;
      if (hit_reg(word_idx, mic_pkg::ADDR_WAKEUP_EDGE))
        prdata_ff[7:0] <= wakeup_edge_select_ff;
      if (hit_reg(word_idx, mic_pkg::ADDR_REQ_EDGE))
        prdata_ff[7:0] <= mic_pkg::REQ_EDGE_FIXED | {3'h0, request_edge_select_ff}; // [RQ14]
      if (hit_reg(word_idx, mic_pkg::ADDR_ENABLE_ONE))
        prdata_ff[7:0] <= source_enable_one_ff;
      if (hit_reg(word_idx, mic_pkg::ADDR_ENABLE_TWO))
        prdata_ff[7:0] <= source_enable_two_ff;
      if (hit_reg(word_idx, mic_pkg::ADDR_PEND_ONE))
        prdata_ff[7:0] <= pending_flags_one_ff;
      if (hit_reg(word_idx, mic_pkg::ADDR_PEND_TWO))
        prdata_ff[7:0] <= pending_flags_two_ff;
      if (hit_reg(word_idx, mic_pkg::ADDR_WAKEUP_PEND))
        prdata_ff[7:0] <= wakeup_pending_flags_ff;
    end
  end
  assign prdata = prdata_ff;
endmodule : mic_interrupt_controller

// ### verif/mic_chk.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module mic_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic [5:0] serial1_event,
  input wire logic [5:0] serial2_event,
  input wire logic global_mask,
  input wire logic irq_ack,
  input wire logic irq,
  input wire logic [4:0] irq_vector,
  input wire logic [15:0] irq_vector_addr,
  input wire logic timer_c_pin_hit,
  input wire logic converter_trigger_hit
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_serial1_held;
    (|serial1_event && !global_mask && !irq_ack)[*3];
  endsequence
  sequence s_edge_read;
    psel && penable && !pwrite && paddr[17:2] == mic_pkg::ADDR_REQ_EDGE;
  endsequence
  a_mask_blocks_irq: assert property (global_mask |=> !irq)
    else $error("irq raised while masked");
  a_vector_addr_pair: assert property (irq |-> irq_vector_addr == {10'h000, irq_vector, 1'h0})
    else $error("vector address not twice the vector");
  a_vector_legal: assert property (irq |-> irq_vector inside {[5'h04:5'h09], [5'h0B:5'h14]})
    else $error("reserved vector issued");
  a_serial_served: assert property (s_serial1_held |-> irq && irq_vector <= mic_pkg::VEC_SERIAL1)
    else $error("serial request not raised");
  a_serial_outranks: assert property ((|serial2_event)[*3] |->
    !(irq && irq_vector > mic_pkg::VEC_SERIAL2)) else $error("lower vector beat serial");
  a_edge_fixed_ones: assert property (s_edge_read |-> prdata[7:5] == 3'h7)
    else $error("edge select top bits not ones");
  a_ack_drops_irq: assert property (irq_ack |=> !irq)
    else $error("irq held through ack");
  a_c_hit_single: assert property (timer_c_pin_hit |=> !timer_c_pin_hit)
    else $error("timer pin hit too long");
  a_trig_hit_single: assert property (converter_trigger_hit |=> !converter_trigger_hit)
    else $error("trigger hit too long");
endmodule : mic_chk
bind mic_interrupt_controller mic_chk i_mic_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .serial1_event, .serial2_event, .global_mask, .irq_ack, .irq, .irq_vector,
  .irq_vector_addr, .timer_c_pin_hit, .converter_trigger_hit);

// ### verif/mic_core_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Core: takes a vector once irq stood steady
// ----------------------------------------
module mic_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq,
  input wire logic [4:0] irq_vector,
  input wire logic [15:0] irq_vector_addr,
  input wire logic [3:0] ack_delay,
  output logic irq_ack,
  output logic [4:0] taken_vector,
  output logic [15:0] taken_addr
);
  logic [3:0] wait_ff;
  logic [4:0] seen_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_ff <= 4'h0;
      seen_ff <= 5'h00;
      irq_ack <= 1'h0;
      taken_vector <= 5'h00;
      taken_addr <= 16'h0000;
    end
    else
    begin
      irq_ack <= 1'h0;
      if (!irq || irq_ack || irq_vector != seen_ff)
      begin
        wait_ff <= 4'h0;
        seen_ff <= irq_vector;
      end
      else if (wait_ff == ack_delay)
      begin
        irq_ack <= 1'h1;
        taken_vector <= irq_vector;
        taken_addr <= irq_vector_addr;
        wait_ff <= 4'h0;
      end
      else
        wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule : mic_core_model

// ### verif/test_mic_interrupt_controller.sv
`timescale 1ns/1ps
module test_mic_interrupt_controller;
  localparam logic [15:0] P1 = mic_pkg::ADDR_PEND_ONE;
  localparam logic [15:0] P2 = mic_pkg::ADDR_PEND_TWO;
  localparam logic [15:0] WP = mic_pkg::ADDR_WAKEUP_PEND;
  localparam logic [15:0] EN1 = mic_pkg::ADDR_ENABLE_ONE;
  localparam logic [15:0] REGS [7] = '{mic_pkg::ADDR_WAKEUP_EDGE, mic_pkg::ADDR_REQ_EDGE, EN1,
    mic_pkg::ADDR_ENABLE_TWO, P1, P2, WP};
  localparam logic [7:0] RSTS [7] = '{8'h00, 8'hE0, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00};
  localparam logic [15:0] CLR_ADR [10] = '{P1, P2, P2, P2, P2, P2, 16'h0000, 16'h0000, P2, P2};
  localparam logic [7:0] CLR_DAT [10] = '{8'h7F, 8'hFE, 8'hFD, 8'hFB, 8'hF7, 8'hEF, 8'h00,
    8'h00, 8'hBF, 8'h7F};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq, irq_ack, global_mask;
  logic timer_f_event_pin, timer_c_event_pin, converter_trigger_pin, timer_a_ovf, event_cnt_ovf;
  logic conv_end, sleep_exec, timer_f_pin_hit, timer_c_pin_hit, converter_trigger_hit;
  logic [1:0] timer_c_event, timer_fl_event, timer_fh_event, timer_g_event;
  logic [5:0] serial1_event, serial2_event;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [4:0] request_pin, irq_vector, taken_vector;
  logic [7:0] wakeup_pin, rd;
  logic [15:0] irq_vector_addr, taken_addr;
  logic [3:0] ack_delay, n_hit_f = 4'h0, n_hit_c = 4'h0, n_hit_cv = 4'h0;
  int mismatches = 0, checks = 0, cycles = 0;
  mic_interrupt_controller i_mic_interrupt_controller (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .request_pin, .wakeup_pin, .timer_f_event_pin,
    .timer_c_event_pin, .converter_trigger_pin, .timer_a_ovf, .event_cnt_ovf, .timer_c_event,
    .timer_fl_event, .timer_fh_event, .timer_g_event, .serial1_event, .serial2_event, .conv_end,
    .sleep_exec, .global_mask, .irq_ack, .irq, .irq_vector, .irq_vector_addr, .timer_f_pin_hit,
    .timer_c_pin_hit, .converter_trigger_hit);
  mic_core_model i_mic_core_model (.pclk, .presetn, .irq, .irq_vector, .irq_vector_addr,
    .ack_delay, .irq_ack, .taken_vector, .taken_addr);
  initial
  begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  always @(negedge pclk)
  begin
    if (timer_f_pin_hit === 1'h1) n_hit_f++;
    if (timer_c_pin_hit === 1'h1) n_hit_c++;
    if (converter_trigger_hit === 1'h1) n_hit_cv++;
  end
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      $display("ERROR at %0t: run hung", $time);
      tally_and_finish;
    end
  end
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {a, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    apb(1'h0, a, 8'h00);
    chk({8'h00, rd}, {8'h00, e});
  endtask : rd_chk
  task automatic serve(input logic [4:0] v);
    int i;
    i = 0;
    @(posedge pclk);
    while (irq_ack !== 1'h1 && i < 300)
    begin
      @(posedge pclk);
      i++;
    end
    chk({15'h0000, irq_ack}, 16'h0001);
    @(negedge pclk);
    chk({11'h000, taken_vector}, {11'h000, v});
    chk(taken_addr, {10'h000, v, 1'h0});
  endtask : serve
  task automatic pins(input logic v);
    @(posedge pclk);
    request_pin <= {5{v}};
    {timer_f_event_pin, timer_c_event_pin, converter_trigger_pin} <= {3{v}};
    repeat (3) @(posedge pclk);
  endtask : pins
  task automatic wake(input logic [7:0] v);
    @(posedge pclk);
    wakeup_pin <= v;
    repeat (3) @(posedge pclk);
  endtask : wake
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {presetn, global_mask, ack_delay} = 6'h14;
    {request_pin, wakeup_pin} = 13'h1FFF;
    {timer_f_event_pin, timer_c_event_pin, converter_trigger_pin} = 3'h7;
    {timer_a_ovf, event_cnt_ovf, conv_end, sleep_exec} = 4'h0;
    {timer_c_event, timer_fl_event, timer_fh_event, timer_g_event} = 8'h00;
    {serial1_event, serial2_event} = 12'h000;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 7; i++)
      rd_chk(REGS[i], RSTS[i]);
    apb(1'h0, 16'hFFF5, 8'h00);
    chk({7'h00, err, rd}, 16'h0100);
    apb(1'h1, mic_pkg::ADDR_REQ_EDGE, 8'h15);
    rd_chk(mic_pkg::ADDR_REQ_EDGE, 8'hF5);
    apb(1'h1, P1, 8'h00);
    pins(1'h0);
    rd_chk(P1, 8'h0A);
    chk({4'h0, n_hit_f, n_hit_c, n_hit_cv}, 16'h0110);
    apb(1'h1, P1, 8'h00);
    pins(1'h1);
    rd_chk(P1, 8'h15);
    chk({4'h0, n_hit_f, n_hit_c, n_hit_cv}, 16'h0111);
    apb(1'h1, EN1, 8'h1F);
    global_mask <= 1'h0;
    for (int k = 0; k < 5; k += 2)
    begin
      serve(5'(4 + k));
      apb(1'h1, P1, ~(8'h01 << k));
    end
    rd_chk(P1, 8'h00);
    apb(1'h1, mic_pkg::ADDR_WAKEUP_EDGE, 8'h0F);
    wake(8'h00);
    rd_chk(WP, 8'hF0);
    wake(8'hFF);
    rd_chk(WP, 8'hFF);
    apb(1'h1, WP, 8'h0F);
    rd_chk(WP, 8'h0F);
    ack_delay <= 4'h9;
    apb(1'h1, EN1, 8'h20);
    serve(5'h09);
    apb(1'h1, WP, 8'h00);
    apb(1'h1, P1, 8'h00);
    global_mask <= 1'h1;
    ack_delay <= 4'h4;
    apb(1'h1, EN1, 8'h80);
    apb(1'h1, mic_pkg::ADDR_ENABLE_TWO, 8'hFF);
    @(posedge pclk);
    {timer_a_ovf, event_cnt_ovf, conv_end, sleep_exec} <= 4'hF;
    {timer_c_event, timer_fl_event, timer_fh_event, timer_g_event} <= 8'h9A;
    {serial1_event, serial2_event} <= 12'h801;
    @(posedge pclk);
    {timer_a_ovf, event_cnt_ovf, conv_end, sleep_exec} <= 4'h0;
    {timer_c_event, timer_fl_event, timer_fh_event, timer_g_event} <= 8'h00;
    repeat (4) @(posedge pclk);
    chk({15'h0000, irq}, 16'h0000);
    rd_chk(P1, 8'h80);
    rd_chk(P2, 8'hDF);
    global_mask <= 1'h0;
    for (int i = 0; i < 10; i++)
    begin
      serve(5'(11 + i));
      if (CLR_ADR[i] != 16'h0000)
        apb(1'h1, CLR_ADR[i], CLR_DAT[i]);
      else
      begin
        @(posedge pclk);
        serial1_event <= 6'h00;
        if (i == 7) serial2_event <= 6'h00;
      end
    end
    rd_chk(P2, 8'h00);
    tally_and_finish;
  end
endmodule : test_mic_interrupt_controller
